// ### rms_ctrl.sv
// operating-mode controller of the packet transceiver
// Operation
// - carrier frequency is 2400 plus channel MHz
// - air rate is 1 or 2 Mbps
// - both ends need same channel and rate
// - power-up low gives power down, port alive
// - power-up high, enable low gives standby-I
// - transmitter, enable high, empty FIFO: standby-II
// - transmit needs payload and long enable pulse
// - after packet: standby-I, next packet, standby-II
// - retransmit after delay while retries below limit
// - transmitter listens only when acknowledgement expected
// - receiver answers only when acknowledgement requested
// - receiver enters receive with enable high
// - receiver returns to receive after acknowledgement
// - accept matching, valid packets into free slot
// - drop valid packet when receive FIFO full
// - receiver stays receiving until host moves it
// - carrier detect needs 128 us of energy
// - maskable active-low interrupt output
// - skip-ack packet: standby-I, no acknowledgement sent
module rms_ctrl #(
  parameter int CD_MIN_CYC = rms_pkg::CD_MIN_CYC,
  parameter int RETRY_STEP_CYC = rms_pkg::RETRY_STEP_CYC,
  parameter int ACK_WAIT_CYC = rms_pkg::ACK_WAIT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce_pin,
  input wire logic power_up_bit,
  input wire logic receiver_role_select,
  input wire logic auto_ack_enable,
  input wire logic [rms_pkg::RETRY_W-1:0] retry_limit,
  input wire logic [rms_pkg::RETRY_W-1:0] retry_delay,
  input wire logic [rms_pkg::CHAN_W-1:0] channel_number,
  input wire logic air_rate_select,
  input wire logic tx_skip_ack,
  input wire logic tx_fifo_empty,
  input wire logic rx_fifo_full,
  input wire logic mask_rx_ready,
  input wire logic mask_tx_sent,
  input wire logic mask_max_retry,
  input wire logic clr_rx_ready,
  input wire logic clr_tx_sent,
  input wire logic clr_max_retry,
  input wire logic clk_link,
  input wire logic lnk_pkt_valid,
  input wire logic lnk_addr_match,
  input wire logic lnk_crc_ok,
  input wire logic lnk_skip_ack,
  input wire logic lnk_tx_done,
  input wire logic lnk_ack_rx,
  input wire logic lnk_energy,
  output rms_pkg::rms_state_type mode_r,
  output logic [rms_pkg::FREQ_W-1:0] freq_mhz_r,
  output logic rate_2m_r,
  output logic tx_start_r,
  output logic tx_resend_r,
  output logic ack_payload_r,
  output logic rx_store_r,
  output logic rx_drop_r,
  output logic [rms_pkg::RETRY_W-1:0] retry_counter_r,
  output logic carrier_detect_flag_r,
  output logic rx_ready_r,
  output logic tx_sent_r,
  output logic max_retry_r,
  output logic irq_n_r
);
  rms_pkg::rms_state_type state_nxt;
  rms_pkg::rms_state_type after_tx;

  logic ce_meta_r;
  logic ce_sync_r;
  logic [rms_pkg::CE_CNT_W-1:0] ce_cnt_r;
  logic ce_long_r;
  logic skip_meta_r;
  logic skip_sync_r;
  logic energy_meta_r;
  logic energy_sync_r;
  logic lnk_rst_meta_r;
  logic lnk_rst_r;
  logic lnk_pkt_ok_r;
  logic lnk_skip_r;
  logic [rms_pkg::EVT_N-1:0] lnk_evt;
  logic [rms_pkg::EVT_N-1:0] sys_evt;
  logic [rms_pkg::WAIT_CNT_W-1:0] wait_cnt_r;
  logic [rms_pkg::WAIT_CNT_W-1:0] retry_wait_cyc;
  logic retry_pend_r;
  logic primary_transmitter;
  logic pkt_ok;
  logic tx_done;
  logic ack_rx;
  logic ack_timeout;
  logic retry_due;
  logic retry_more;
  logic fresh_tx;
  logic ptx_sent;

  assign primary_transmitter = !receiver_role_select;
  assign pkt_ok = sys_evt[rms_pkg::EVT_PKT];
  assign tx_done = sys_evt[rms_pkg::EVT_TXDONE];
  assign ack_rx = sys_evt[rms_pkg::EVT_ACK];

  // ---------------- link domain ----------------
  // link reset is taken from the system reset through two stages
  always_ff @(posedge clk_link) begin
    lnk_rst_meta_r <= rst;
    lnk_rst_r <= lnk_rst_meta_r;
  end

  always_ff @(posedge clk_link) begin
    if (lnk_rst_r) begin
      lnk_pkt_ok_r <= 1'b0;
      lnk_skip_r <= 1'b0;
    end else begin
      lnk_pkt_ok_r <= lnk_pkt_valid && lnk_addr_match && lnk_crc_ok;
      if (lnk_pkt_valid) begin
        lnk_skip_r <= lnk_skip_ack;
      end
    end
  end

  assign lnk_evt[rms_pkg::EVT_PKT] = lnk_pkt_ok_r;
  assign lnk_evt[rms_pkg::EVT_TXDONE] = lnk_tx_done;
  assign lnk_evt[rms_pkg::EVT_ACK] = lnk_ack_rx;

  genvar gi;
  generate
    for (gi = 0; gi < rms_pkg::EVT_N; gi++) begin : g_evt
      rms_evt_cdc u_cdc (
        .clk_src(clk_link),
        .rst_src(lnk_rst_r),
        .evt_src(lnk_evt[gi]),
        .clk_dst(clk_sys),
        .rst_dst(rst),
        .evt_dst(sys_evt[gi])
      );
    end
  endgenerate

  // ---------------- system domain ----------------
  // skip flag is held per packet and settles before the slower event pulse
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ce_meta_r <= 1'b0;
      ce_sync_r <= 1'b0;
      skip_meta_r <= 1'b0;
      skip_sync_r <= 1'b0;
      energy_meta_r <= 1'b0;
      energy_sync_r <= 1'b0;
    end else begin
      ce_meta_r <= ce_pin;
      ce_sync_r <= ce_meta_r;
      skip_meta_r <= lnk_skip_r;
      skip_sync_r <= skip_meta_r;
      energy_meta_r <= lnk_energy;
      energy_sync_r <= energy_meta_r;
    end
  end

  // one standby-I start per long enable pulse: a held enable cannot restart a failed send
  always_ff @(posedge clk_sys) begin
    if (rst || !ce_sync_r) begin
      ce_cnt_r <= '0;
      ce_long_r <= 1'b0;
    end else if (ce_cnt_r < rms_pkg::CE_CNT_W'(rms_pkg::CE_MIN_CYC)) begin
      ce_cnt_r <= ce_cnt_r + 1'b1;
      ce_long_r <= ce_cnt_r == rms_pkg::CE_CNT_W'(rms_pkg::CE_MIN_CYC - 1);
    end else if (mode_r == rms_pkg::ST_STBY1 && state_nxt == rms_pkg::ST_TX) begin
      ce_long_r <= 1'b0;
    end
  end

  // one counter times both the ack wait and the retry delay
  always_ff @(posedge clk_sys) begin
    if (rst || state_nxt != mode_r) begin
      wait_cnt_r <= '0;
    end else if (wait_cnt_r != '1) begin
      wait_cnt_r <= wait_cnt_r + 1'b1;
    end
  end

  assign retry_wait_cyc =
    rms_pkg::WAIT_CNT_W'((int'(retry_delay) + 1) * RETRY_STEP_CYC);
  assign ack_timeout = primary_transmitter && mode_r == rms_pkg::ST_RX && !ack_rx &&
    wait_cnt_r >= rms_pkg::WAIT_CNT_W'(ACK_WAIT_CYC - 1);
  assign retry_more = retry_counter_r < retry_limit;
  assign retry_due = retry_pend_r && wait_cnt_r >= retry_wait_cyc - 1'b1;
  assign fresh_tx = primary_transmitter && state_nxt == rms_pkg::ST_TX && !retry_pend_r &&
    (mode_r != rms_pkg::ST_TX || tx_done);
  assign ptx_sent = primary_transmitter && ((mode_r == rms_pkg::ST_TX && tx_done &&
    (!auto_ack_enable || tx_skip_ack)) || (mode_r == rms_pkg::ST_RX && ack_rx));

  always_comb begin
    if (!ce_sync_r) begin
      after_tx = rms_pkg::ST_STBY1;
    end else if (!tx_fifo_empty) begin
      after_tx = rms_pkg::ST_TX;
    end else begin
      after_tx = rms_pkg::ST_STBY2;
    end
  end

  // with auto-ack off no automatic ack or retry step is ever taken
  always_comb begin
    state_nxt = mode_r;
    case (mode_r)
      rms_pkg::ST_PDN: begin
        if (power_up_bit) begin
          state_nxt = rms_pkg::ST_STBY1;
        end
      end
      rms_pkg::ST_STBY1: begin
        if (!primary_transmitter) begin
          if (ce_sync_r) begin
            state_nxt = rms_pkg::ST_RX;
          end
        end else if (retry_pend_r) begin
          if (retry_due) begin
            state_nxt = rms_pkg::ST_TX;
          end
        end else if (ce_long_r && !tx_fifo_empty) begin
          state_nxt = rms_pkg::ST_TX;
        end else if (ce_sync_r && tx_fifo_empty) begin
          state_nxt = rms_pkg::ST_STBY2;
        end
      end
      rms_pkg::ST_STBY2: begin
        if (!ce_sync_r || !primary_transmitter) begin
          state_nxt = rms_pkg::ST_STBY1;
        end else if (!tx_fifo_empty) begin
          state_nxt = rms_pkg::ST_TX;
        end
      end
      rms_pkg::ST_TX: begin
        if (tx_done) begin
          if (!primary_transmitter) begin
            state_nxt = ce_sync_r ? rms_pkg::ST_RX : rms_pkg::ST_STBY1;
          end else if (auto_ack_enable && !tx_skip_ack) begin
            state_nxt = rms_pkg::ST_RX;
          end else if (auto_ack_enable) begin
            state_nxt = rms_pkg::ST_STBY1;
          end else begin
            state_nxt = after_tx;
          end
        end
      end
      rms_pkg::ST_RX: begin
        if (primary_transmitter) begin
          if (ack_rx) begin
            state_nxt = after_tx;
          end else if (ack_timeout) begin
            state_nxt = rms_pkg::ST_STBY1;
          end
        end else if (!ce_sync_r) begin
          state_nxt = rms_pkg::ST_STBY1;
        end else if (pkt_ok && !rx_fifo_full && auto_ack_enable && !skip_sync_r) begin
          state_nxt = rms_pkg::ST_TX;
        end
      end
      default: begin
        state_nxt = rms_pkg::ST_PDN;
      end
    endcase
    if (!power_up_bit) begin
      state_nxt = rms_pkg::ST_PDN;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_r <= rms_pkg::ST_PDN;
    end else begin
      mode_r <= state_nxt;
    end
  end

  // retry bookkeeping of the transmitter role
  always_ff @(posedge clk_sys) begin
    if (rst || !power_up_bit) begin
      retry_pend_r <= 1'b0;
      retry_counter_r <= '0;
    end else if (fresh_tx) begin
      retry_pend_r <= 1'b0;
      retry_counter_r <= '0;
    end else if (ack_rx && primary_transmitter && mode_r == rms_pkg::ST_RX) begin
      retry_pend_r <= 1'b0;
    end else if (ack_timeout) begin
      retry_pend_r <= retry_more;
      if (retry_more) begin
        retry_counter_r <= retry_counter_r + 1'b1;
      end
    end else if (retry_due && mode_r == rms_pkg::ST_STBY1) begin
      retry_pend_r <= 1'b0;
    end
  end

  // retransmit keeps its pending flag until the delay expires, so it marks the resend
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_start_r <= 1'b0;
      tx_resend_r <= 1'b0;
      ack_payload_r <= 1'b0;
    end else begin
      tx_start_r <= state_nxt == rms_pkg::ST_TX && (mode_r != rms_pkg::ST_TX || tx_done);
      tx_resend_r <= primary_transmitter && retry_due && mode_r == rms_pkg::ST_STBY1 && power_up_bit;
      if (!primary_transmitter && mode_r == rms_pkg::ST_RX && state_nxt == rms_pkg::ST_TX) begin
        ack_payload_r <= !tx_fifo_empty;
      end
    end
  end

  // receive acceptance; only the receiver role stores payload here
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_store_r <= 1'b0;
      rx_drop_r <= 1'b0;
    end else begin
      rx_store_r <= !primary_transmitter && mode_r == rms_pkg::ST_RX && pkt_ok && !rx_fifo_full;
      rx_drop_r <= !primary_transmitter && mode_r == rms_pkg::ST_RX && pkt_ok && rx_fifo_full;
    end
  end

  // frequency and rate must match the far end to talk at all
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      freq_mhz_r <= rms_pkg::CHAN_BASE_MHZ;
      rate_2m_r <= 1'b0;
    end else begin
      freq_mhz_r <= rms_pkg::CHAN_BASE_MHZ + rms_pkg::FREQ_W'(channel_number);
      rate_2m_r <= air_rate_select;
    end
  end

  rms_cd_filter #(
    .MIN_CYC(CD_MIN_CYC)
  ) u_cd (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(mode_r == rms_pkg::ST_RX),
    .energy(energy_sync_r),
    .flag_r(carrier_detect_flag_r)
  );

  // sticky flags: a set in the clear cycle wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_ready_r <= rms_pkg::FLAG_RST;
      tx_sent_r <= rms_pkg::FLAG_RST;
      max_retry_r <= rms_pkg::FLAG_RST;
    end else begin
      rx_ready_r <= rx_store_r || (rx_ready_r && !clr_rx_ready);
      tx_sent_r <= ptx_sent || (tx_sent_r && !clr_tx_sent);
      max_retry_r <= (ack_timeout && !retry_more) || (max_retry_r && !clr_max_retry);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_n_r <= rms_pkg::IRQ_N_RST;
    end else begin
      irq_n_r <= !((rx_ready_r && !mask_rx_ready) || (tx_sent_r && !mask_tx_sent) ||
        (max_retry_r && !mask_max_retry));
    end
  end
endmodule

// ### rms_pkg.sv
// shared constants and types of the radio mode state controller
package rms_pkg;

  typedef enum logic [4:0] {
    ST_PDN   = 5'h01,
    ST_STBY1 = 5'h02,
    ST_STBY2 = 5'h04,
    ST_TX    = 5'h08,
    ST_RX    = 5'h10
  } rms_state_type;

  localparam int CLK_PERIOD_PS = 5000;

  localparam int CE_MIN_NS = 10000;
  localparam int CE_MIN_CYC = (CE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CE_CNT_W = 12;

  localparam int CD_MIN_US = 128;
  localparam int CD_MIN_CYC = (CD_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CD_CNT_W = 16;

  // retry delay step and ack wait are not given; plain defaults
  localparam int RETRY_STEP_US = 250;
  localparam int RETRY_STEP_CYC = (RETRY_STEP_US * 1000000) / CLK_PERIOD_PS;
  localparam int ACK_WAIT_US = 250;
  localparam int ACK_WAIT_CYC = (ACK_WAIT_US * 1000000) / CLK_PERIOD_PS;
  localparam int WAIT_CNT_W = 20;

  localparam int CHAN_W = 7;
  localparam int FREQ_W = 12;
  localparam int RETRY_W = 4;
  localparam logic [FREQ_W-1:0] CHAN_BASE_MHZ = 12'h960;

  localparam int EVT_N = 3;
  localparam int EVT_PKT = 0;
  localparam int EVT_TXDONE = 1;
  localparam int EVT_ACK = 2;

  localparam logic FLAG_RST = 1'b0;
  localparam logic IRQ_N_RST = 1'b1;

endpackage

// ### rms_evt_cdc.sv
// toggle crossing of a one-cycle event from one clock to another
module rms_evt_cdc (
  input wire logic clk_src,
  input wire logic rst_src,
  input wire logic evt_src,
  input wire logic clk_dst,
  input wire logic rst_dst,
  output logic evt_dst
);
  logic tgl_r;
  logic meta_r;
  logic sync_r;
  logic last_r;

  always_ff @(posedge clk_src) begin
    if (rst_src) begin
      tgl_r <= 1'b0;
    end else if (evt_src) begin
      tgl_r <= ~tgl_r;
    end
  end

  // meta_r feeds sync_r only
  always_ff @(posedge clk_dst) begin
    if (rst_dst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
      evt_dst <= 1'b0;
    end else begin
      meta_r <= tgl_r;
      sync_r <= meta_r;
      last_r <= sync_r;
      evt_dst <= sync_r ^ last_r;
    end
  end
endmodule

// ### rms_cd_filter.sv
// carrier detect filter: energy must persist a minimum time
module rms_cd_filter #(
  parameter int MIN_CYC = rms_pkg::CD_MIN_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic enable,
  input wire logic energy,
  output logic flag_r
);
  logic [rms_pkg::CD_CNT_W-1:0] cnt_r;
  logic done;

  assign done = cnt_r >= rms_pkg::CD_CNT_W'(MIN_CYC - 1);

  // any gap in energy restarts the count
  always_ff @(posedge clk_sys) begin
    if (rst || !enable || !energy) begin
      cnt_r <= '0;
      flag_r <= 1'b0;
    end else if (done) begin
      flag_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule

// ### rms_ctrl_asserts.sv
// port assertions of the radio mode controller
module rms_ctrl_asserts #(
  parameter int CD_MIN_CYC = rms_pkg::CD_MIN_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce_pin,
  input wire logic power_up_bit,
  input wire logic receiver_role_select,
  input wire logic tx_fifo_empty,
  input wire logic rx_fifo_full,
  input wire logic lnk_energy,
  input wire rms_pkg::rms_state_type mode_r,
  input wire logic tx_start_r,
  input wire logic tx_resend_r,
  input wire logic rx_store_r,
  input wire logic rx_drop_r,
  input wire logic [rms_pkg::RETRY_W-1:0] retry_counter_r,
  input wire logic carrier_detect_flag_r
);
  // raw energy run length in receive; the design's synchronised copy lags it
  logic [15:0] en_cnt_r;
  always_ff @(posedge clk_sys) begin
    if (rst || !lnk_energy || mode_r != rms_pkg::ST_RX) begin
      en_cnt_r <= 16'h0000;
    end else if (en_cnt_r != 16'hFFFF) begin
      en_cnt_r <= en_cnt_r + 16'h0001;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_power_down_forced: assert property (!power_up_bit |=> mode_r == rms_pkg::ST_PDN)
    else $error("power down not entered");
  a_start_in_tx: assert property (tx_start_r |-> mode_r == rms_pkg::ST_TX)
    else $error("start outside transmit");
  a_resend_counted: assert property (tx_resend_r |-> tx_start_r && retry_counter_r != 0)
    else $error("resend without retry");
  a_stby2_to_tx: assert property ((ce_pin && power_up_bit && !receiver_role_select)[*4]
    ##0 (mode_r == rms_pkg::ST_STBY2 && !tx_fifo_empty) |-> ##[1:2] mode_r == rms_pkg::ST_TX)
    else $error("standby-II did not transmit");
  a_ce_low_leaves: assert property ((!ce_pin && power_up_bit && receiver_role_select)[*6]
    |-> mode_r != rms_pkg::ST_RX)
    else $error("receive kept with enable low");
  a_store_in_rx: assert property (rx_store_r |-> $past(mode_r) == rms_pkg::ST_RX && !rx_drop_r)
    else $error("store outside receive");
  a_drop_when_full: assert property (rx_drop_r |-> $past(rx_fifo_full))
    else $error("drop with free slot");
  a_cd_filtered: assert property ($rose(carrier_detect_flag_r) |-> en_cnt_r >= CD_MIN_CYC)
    else $error("carrier flag too early");
  c_tx: cover property (mode_r == rms_pkg::ST_TX);
  c_drop: cover property (rx_drop_r);
  c_resend: cover property (tx_resend_r);
endmodule

bind rms_ctrl rms_ctrl_asserts #(.CD_MIN_CYC(CD_MIN_CYC)) u_rms_ctrl_asserts (
  .clk_sys, .rst, .ce_pin, .power_up_bit, .receiver_role_select, .tx_fifo_empty,
  .rx_fifo_full, .lnk_energy, .mode_r, .tx_start_r, .tx_resend_r, .rx_store_r,
  .rx_drop_r, .retry_counter_r, .carrier_detect_flag_r);

// ### rms_link_model.sv
// behavioural radio front end making link-domain events
module rms_link_model (
  output logic lnk_pkt_valid,
  output logic lnk_addr_match,
  output logic lnk_crc_ok,
  output logic lnk_skip_ack,
  output logic lnk_tx_done,
  output logic lnk_ack_rx,
  output logic lnk_energy,
  input wire logic clk_link
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {lnk_pkt_valid, lnk_tx_done, lnk_ack_rx, lnk_energy} = 4'h0;
    {lnk_addr_match, lnk_crc_ok, lnk_skip_ack} = 3'h5;
  end
  // w: 0 sent, 1 ack heard, 2 packet; qualifiers invert once the packet ends
  // so stale values never pass; the far end shares channel and rate
  task automatic evt(input int w, input logic [2:0] q);
    @(posedge clk_link);
    #2;
    lnk_pkt_valid = (w == 2);
    lnk_tx_done = (w == 0);
    lnk_ack_rx = (w == 1);
    {lnk_addr_match, lnk_crc_ok, lnk_skip_ack} = q;
    @(posedge clk_link);
    #2;
    {lnk_pkt_valid, lnk_tx_done, lnk_ack_rx} = 3'h0;
    {lnk_addr_match, lnk_crc_ok, lnk_skip_ack} = ~q;
    @(posedge clk_link);
  endtask
  task automatic set_energy(input logic v);
    @(posedge clk_link);
    #2;
    lnk_energy = v;
  endtask
endmodule

// ### rms_ctrl_tb.sv
// self-checking bench of the radio mode controller
module rms_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 0, clk_link = 0, rst = 1, ce_pin = 0, power_up_bit = 0;
  logic receiver_role_select = 0, auto_ack_enable = 0, air_rate_select = 0;
  logic tx_skip_ack = 0, tx_fifo_empty = 1, rx_fifo_full = 0, mask_rx_ready = 0;
  logic mask_tx_sent = 0, mask_max_retry = 0, clr_rx_ready = 0, clr_tx_sent = 0;
  logic clr_max_retry = 0;
  logic [3:0] retry_limit = 4'h1, retry_delay = 4'h0;
  logic [6:0] channel_number = 7'h00;
  logic lnk_pkt_valid, lnk_addr_match, lnk_crc_ok, lnk_skip_ack;
  logic lnk_tx_done, lnk_ack_rx, lnk_energy;
  rms_pkg::rms_state_type mode_r;
  logic [11:0] freq_mhz_r;
  logic [3:0] retry_counter_r;
  logic rate_2m_r, tx_start_r, tx_resend_r, ack_payload_r, rx_store_r, rx_drop_r;
  logic carrier_detect_flag_r, rx_ready_r, tx_sent_r, max_retry_r, irq_n_r;
  int fails = 0, total_checks = 0, n_start = 0, n_resend = 0, n_store = 0, n_drop = 0;
  always #2.5 clk_sys = ~clk_sys;
  always #40 clk_link = ~clk_link;
  rms_ctrl #(.CD_MIN_CYC(20), .RETRY_STEP_CYC(30), .ACK_WAIT_CYC(120)) u_rms_ctrl (
    .clk_sys, .rst, .ce_pin, .power_up_bit, .receiver_role_select, .auto_ack_enable,
    .retry_limit, .retry_delay, .channel_number, .air_rate_select, .tx_skip_ack,
    .tx_fifo_empty, .rx_fifo_full, .mask_rx_ready, .mask_tx_sent, .mask_max_retry,
    .clr_rx_ready, .clr_tx_sent, .clr_max_retry, .clk_link, .lnk_pkt_valid,
    .lnk_addr_match, .lnk_crc_ok, .lnk_skip_ack, .lnk_tx_done, .lnk_ack_rx, .lnk_energy,
    .mode_r, .freq_mhz_r, .rate_2m_r, .tx_start_r, .tx_resend_r, .ack_payload_r,
    .rx_store_r, .rx_drop_r, .retry_counter_r, .carrier_detect_flag_r, .rx_ready_r,
    .tx_sent_r, .max_retry_r, .irq_n_r);
  rms_link_model u_link (.clk_link, .lnk_pkt_valid, .lnk_addr_match, .lnk_crc_ok,
    .lnk_skip_ack, .lnk_tx_done, .lnk_ack_rx, .lnk_energy);
  // pulses last one cycle, so they are counted rather than sampled late
  always @(posedge clk_sys) begin
    n_start <= n_start + (tx_start_r === 1'b1);
    n_resend <= n_resend + (tx_resend_r === 1'b1);
    n_store <= n_store + (rx_store_r === 1'b1);
    n_drop <= n_drop + (rx_drop_r === 1'b1);
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic mode_is(input rms_pkg::rms_state_type m, input int lim);
    for (int i = 0; i < lim && mode_r !== m; i++) begin
      tick(1);
    end
    check(12'(mode_r), 12'(m));
  endtask
  task automatic link_evt(input int w, input logic [2:0] q);
    u_link.evt(w, q);
    tick(8);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    tally_and_finish();
  end
  initial begin
    // reset also spans three link edges so the link side leaves reset cleanly
    repeat (12) @(posedge clk_sys);
    repeat (3) @(posedge clk_link);
    tick(1);
    rst = 0;
    tick(1);
    mode_is(rms_pkg::ST_PDN, 0);
    check(12'(irq_n_r), 12'h001);
    power_up_bit = 1;
    for (int k = 0; k < 2; k++) begin
      channel_number = k ? 7'h7F : 7'h00;
      air_rate_select = k[0];
      tick(3);
      check(freq_mhz_r, 12'h960 + 12'(channel_number));
      check(12'(rate_2m_r), 12'(k));
    end
    mode_is(rms_pkg::ST_STBY1, 0);
    $display("test config done");
    tx_fifo_empty = 0;
    ce_pin = 1;
    tick(1990);
    check(12'(mode_r == rms_pkg::ST_TX), 12'h000);
    mode_is(rms_pkg::ST_TX, 40);
    link_evt(0, 3'h0);
    check(12'(n_start), 12'h002);
    tx_fifo_empty = 1;
    link_evt(0, 3'h0);
    mode_is(rms_pkg::ST_STBY2, 0);
    check(12'(irq_n_r), 12'h000);
    mask_tx_sent = 1;
    tick(3);
    check(12'(irq_n_r), 12'h001);
    tx_fifo_empty = 0;
    mode_is(rms_pkg::ST_TX, 3);
    ce_pin = 0;
    link_evt(0, 3'h0);
    mode_is(rms_pkg::ST_STBY1, 0);
    clr_tx_sent = 1;
    tick(1);
    clr_tx_sent = 0;
    mask_tx_sent = 0;
    tick(2);
    check(12'(tx_sent_r), 12'h000);
    $display("test manual transmit done");
    auto_ack_enable = 1;
    ce_pin = 1;
    mode_is(rms_pkg::ST_TX, 2100);
    link_evt(0, 3'h0);
    mode_is(rms_pkg::ST_RX, 0);
    mode_is(rms_pkg::ST_STBY1, 100);
    check(12'(retry_counter_r), 12'h001);
    mode_is(rms_pkg::ST_TX, 50);
    tick(1);
    check(12'(n_resend), 12'h001);
    link_evt(0, 3'h0);
    mode_is(rms_pkg::ST_STBY1, 100);
    check(12'(max_retry_r), 12'h001);
    tick(60);
    mode_is(rms_pkg::ST_STBY1, 0);
    ce_pin = 0;
    tick(4);
    ce_pin = 1;
    mode_is(rms_pkg::ST_TX, 2100);
    link_evt(0, 3'h0);
    tx_skip_ack = 1;
    link_evt(1, 3'h0);
    mode_is(rms_pkg::ST_TX, 0);
    link_evt(0, 3'h0);
    mode_is(rms_pkg::ST_STBY1, 0);
    $display("test auto transmit done");
    tx_skip_ack = 0;
    ce_pin = 0;
    receiver_role_select = 1;
    tick(4);
    ce_pin = 1;
    mode_is(rms_pkg::ST_RX, 8);
    link_evt(2, 3'b110);
    check(12'(n_store), 12'h001);
    check(12'(rx_ready_r), 12'h001);
    mode_is(rms_pkg::ST_TX, 0);
    check(12'(ack_payload_r), 12'h001);
    link_evt(0, 3'h0);
    mode_is(rms_pkg::ST_RX, 0);
    link_evt(2, 3'b100);
    link_evt(2, 3'b010);
    link_evt(2, 3'b111);
    check(12'(n_store), 12'h002);
    mode_is(rms_pkg::ST_RX, 0);
    rx_fifo_full = 1;
    link_evt(2, 3'b110);
    check(12'(n_drop), 12'h001);
    check(12'(n_store), 12'h002);
    mode_is(rms_pkg::ST_RX, 0);
    u_link.set_energy(1);
    tick(10);
    check(12'(carrier_detect_flag_r), 12'h000);
    tick(30);
    check(12'(carrier_detect_flag_r), 12'h001);
    u_link.set_energy(0);
    tick(10);
    check(12'(carrier_detect_flag_r), 12'h000);
    tick(200);
    mode_is(rms_pkg::ST_RX, 0);
    ce_pin = 0;
    tick(8);
    mode_is(rms_pkg::ST_STBY1, 0);
    power_up_bit = 0;
    tick(3);
    mode_is(rms_pkg::ST_PDN, 0);
    $display("test receiver done");
    tally_and_finish();
  end
endmodule
